// ===== src/bao_top.sv
// allocation hint override for transactions passing an untranslated context bank
//
// Contract
// R01 - the write override field decodes 10 as force allocate, 11 as force no allocate, 01 reserved.
// R02 - both overrides act only while the bank translation enable bit is 0, else no effect.
// R03 - the read override field decodes 10 as force allocate, 11 as force no allocate, 01 reserved.
// R04 - the read override touches only the read hint of reads, never the write hint.
// R05 - a field of 00 forwards the transaction's own allocation hint unchanged.
// R06 - the write override acts on writes only; control bits 31 to 28 read zero, ignore writes.
//
// Design decisions made here: register access over APB and the register offsets.
`include "bao_regs.svh"
`timescale 1ns/10ps
module bao_top (
  // clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_arst_n,
  // apb slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // transaction in from bus masters
  input  wire logic        i_txn_valid,
  input  wire logic        i_txn_write,
  input  wire logic [3:0]  i_txn_cache,
  // transaction out towards memory
  output logic             o_txn_valid,
  output logic             o_txn_write,
  output logic      [3:0]  o_txn_cache
);

  // control and status state
  logic        m_reg;
  logic [1:0]  wa_reg;
  logic [1:0]  ra_reg;
  logic [15:0] ovr_cnt_reg;
  logic [15:0] ovr_cnt_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic        pready_reg;
  logic        pslverr_reg;
  logic        txn_valid_reg;
  logic        txn_write_reg;
  logic [3:0]  txn_cache_reg;
  logic [3:0]  txn_cache_next;

  // apb decode
  wire setup_ph  = i_psel & ~i_penable;
  wire access_ok = i_psel & i_penable & pready_reg;
  wire hit_ctrl  = (i_paddr == `BAO_CTRL_OFFSET);
  wire hit_stat  = (i_paddr == `BAO_STATUS_OFFSET);
  wire hit_any   = hit_ctrl | hit_stat;
  wire ctrl_wr   = access_ok & i_pwrite & hit_ctrl;

  // read views; upper reserved bits always zero
  wire [31:0] ctrl_view = {4'h0, wa_reg, ra_reg, 23'h000000, m_reg}; // R06
  wire [31:0] stat_view = {15'h0000, m_reg, ovr_cnt_reg};

  // read data mux, loaded in the setup phase
  always_comb begin
    if (hit_ctrl) begin
      prdata_next = ctrl_view;
    end else if (hit_stat) begin
      prdata_next = stat_view;
    end else begin
      prdata_next = 32'h00000000;
    end
  end

  // apb response: one access cycle, error on unmapped address
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h00000000;
    end else begin
      pready_reg  <= setup_ph;
      pslverr_reg <= setup_ph & ~hit_any;
      if (setup_ph) begin
        prdata_reg <= i_pwrite ? 32'h00000000 : prdata_next;
      end
    end
  end

  // control register: bits 31..28 are not stored, so writes there vanish
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      m_reg  <= `BAO_CTRL_M_RESET;
      wa_reg <= `BAO_CTRL_CFG_RESET;
      ra_reg <= `BAO_CTRL_CFG_RESET;
    end else if (ctrl_wr) begin
      m_reg  <= i_pwdata[`BAO_CTRL_M_BIT];
      wa_reg <= i_pwdata[`BAO_CTRL_WA_MSB:`BAO_CTRL_WA_LSB]; // R06
      ra_reg <= i_pwdata[`BAO_CTRL_RA_MSB:`BAO_CTRL_RA_LSB];
    end
  end

  // override hint path
  wire bypass = ~m_reg; // R02
  wire is_wr  = i_txn_valid & i_txn_write;
  wire is_rd  = i_txn_valid & ~i_txn_write;
  wire wa_hint;
  wire ra_hint;
  wire wa_forced;
  wire ra_forced;

  // write hint, only for writes
  bao_hint_ovr u_wa_ovr (
    .i_field   (wa_reg),
    .i_bypass  (bypass),
    .i_applies (is_wr),
    .i_hint    (i_txn_cache[`BAO_CACHE_WA_BIT]),
    .o_hint    (wa_hint),
    .o_forced  (wa_forced)
  ); // R01 R06

  // read hint, only for reads
  bao_hint_ovr u_ra_ovr (
    .i_field   (ra_reg),
    .i_bypass  (bypass),
    .i_applies (is_rd),
    .i_hint    (i_txn_cache[`BAO_CACHE_RA_BIT]),
    .o_hint    (ra_hint),
    .o_forced  (ra_forced)
  ); // R03 R04

  // splice the hints back; other attribute bits pass unchanged
  always_comb begin
    txn_cache_next                    = i_txn_cache; // R05
    txn_cache_next[`BAO_CACHE_WA_BIT] = wa_hint;
    txn_cache_next[`BAO_CACHE_RA_BIT] = ra_hint;
  end

  // count transactions whose hint was replaced
  assign ovr_cnt_next = ovr_cnt_reg + 16'h0001;

  // registered transaction output, one cycle of latency
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      txn_valid_reg <= 1'b0;
      txn_write_reg <= 1'b0;
      txn_cache_reg <= 4'h0;
      ovr_cnt_reg   <= 16'h0000;
    end else begin
      txn_valid_reg <= i_txn_valid;
      txn_write_reg <= i_txn_write;
      txn_cache_reg <= txn_cache_next;
      if (wa_forced | ra_forced) begin
        ovr_cnt_reg <= ovr_cnt_next;
      end
    end
  end

  // outputs straight from flops
  assign o_prdata    = prdata_reg;
  assign o_pready    = pready_reg;
  assign o_pslverr   = pslverr_reg;
  assign o_txn_valid = txn_valid_reg;
  assign o_txn_write = txn_write_reg;
  assign o_txn_cache = txn_cache_reg;

  // checks
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);

  a_wa_force_alloc: assert property ( // R01
    is_wr && !m_reg && wa_reg == 2'b10 |=> o_txn_valid && o_txn_cache[3])
    else $error("write allocate not forced");

  a_wa_rsvd_pass: assert property ( // R01
    is_wr && !m_reg && wa_reg == 2'b01 |=> o_txn_cache[3] == $past(i_txn_cache[3]))
    else $error("reserved write code changed hint");

  a_xlate_on_pass: assert property ( // R02
    i_txn_valid && m_reg |=> o_txn_cache == $past(i_txn_cache))
    else $error("override applied with translation on");

  a_ra_force_none: assert property ( // R03
    is_rd && !m_reg && ra_reg == 2'b11 |=> !o_txn_cache[2] && !o_txn_write)
    else $error("read no allocate not forced");

  a_rd_keeps_wa: assert property ( // R04
    is_rd |=> o_txn_cache[3] == $past(i_txn_cache[3]))
    else $error("read changed write hint");

  a_ra_default: assert property ( // R05
    is_rd && ra_reg == 2'b00 |=> o_txn_cache[2] == $past(i_txn_cache[2]))
    else $error("default read hint not forwarded");

  a_wr_keeps_ra: assert property ( // R06
    is_wr |=> o_txn_cache[2] == $past(i_txn_cache[2]))
    else $error("write changed read hint");

  a_rsvd_reads_zero: assert property ( // R06
    setup_ph && !i_pwrite && hit_ctrl |=> o_pready && o_prdata[31:28] == 4'h0)
    else $error("reserved control bits not zero");

  a_wa_force_none: assert property ( // R01
    is_wr && !m_reg && wa_reg == 2'h3 |=> o_txn_valid && !o_txn_cache[3])
    else $error("write no allocate not forced");

  a_ra_force_alloc: assert property ( // R03
    is_rd && !m_reg && ra_reg == 2'h2 |=> o_txn_valid && o_txn_cache[2])
    else $error("read allocate not forced");

  a_ra_rsvd_pass: assert property ( // R03
    is_rd && !m_reg && ra_reg == 2'h1 |=> o_txn_cache[2] == $past(i_txn_cache[2]))
    else $error("reserved read code changed hint");

  a_wa_default: assert property ( // R05
    is_wr && wa_reg == 2'h0 |=> o_txn_cache[3] == $past(i_txn_cache[3]))
    else $error("default write hint not forwarded");

  a_other_bits_pass: assert property ( // R05
    i_txn_valid |=> o_txn_cache[1:0] == $past(i_txn_cache[1:0]))
    else $error("non hint attribute bits changed");

  a_xlate_on_count: assert property ( // R02
    i_txn_valid && m_reg |=> ovr_cnt_reg == $past(ovr_cnt_reg))
    else $error("override counted with translation on");

endmodule : bao_top

// ===== src/bao_regs.svh
// register offsets, field positions, reset values for the allocation hint override block
`ifndef BAO_REGS_SVH
`define BAO_REGS_SVH

// register byte offsets
`define BAO_CTRL_OFFSET    12'h000
`define BAO_STATUS_OFFSET  12'h004

// control register field positions
`define BAO_CTRL_M_BIT     0
`define BAO_CTRL_RA_LSB    24
`define BAO_CTRL_RA_MSB    25
`define BAO_CTRL_WA_LSB    26
`define BAO_CTRL_WA_MSB    27
`define BAO_CTRL_RSVD_LSB  28
`define BAO_CTRL_RSVD_MSB  31

// control register reset values
`define BAO_CTRL_M_RESET   1'h0
`define BAO_CTRL_CFG_RESET 2'h0

// positions of the allocation hints inside the transaction cache attribute
`define BAO_CACHE_RA_BIT   2
`define BAO_CACHE_WA_BIT   3

`endif

// ===== src/bao_pkg.sv
// types shared by the allocation hint override block
package bao_pkg;

  // two-bit override field encoding
  typedef enum logic [1:0] {
    BAO_ALLOC_PASS  = 2'b00,
    BAO_ALLOC_RSVD  = 2'b01,
    BAO_ALLOC_FORCE = 2'b10,
    BAO_ALLOC_NONE  = 2'b11
  } bao_alloc_cfg_t;

endpackage : bao_pkg

// ===== src/bao_hint_ovr.sv
// one allocation hint override: decodes a two-bit field and replaces one hint bit
`timescale 1ns/10ps
module bao_hint_ovr (
  // override setting
  input  wire logic [1:0] i_field,
  input  wire logic       i_bypass,
  input  wire logic       i_applies,
  // hint in and out
  input  wire logic       i_hint,
  output logic            o_hint,
  output logic            o_forced
);

  // field decode and hint selection
  wire bao_pkg::bao_alloc_cfg_t code     = bao_pkg::bao_alloc_cfg_t'(i_field);
  wire                          active   = i_bypass & i_applies;
  wire                          do_alloc = (code == bao_pkg::BAO_ALLOC_FORCE);
  wire                          do_none  = (code == bao_pkg::BAO_ALLOC_NONE);
  // pass and reserved codes leave the hint alone
  assign o_forced = active & (do_alloc | do_none);
  assign o_hint   = o_forced ? do_alloc : i_hint;

endmodule : bao_hint_ovr

// ===== sim/bao_txn_src.sv
// partner model: an upstream bus master issuing one-cycle transactions
`timescale 1ns/10ps
module bao_txn_src (
  // clock
  input  wire logic       i_mclk,
  // transaction towards the block
  output logic            o_valid,
  output logic            o_write,
  output logic      [3:0] o_cache
);
  initial begin
    o_valid = 1'h0;
    o_write = 1'h0;
    o_cache = 4'h0;
  end
  // one strobe per call; released lines show inverted values, never a stale copy
  task automatic send(input logic w, input logic [3:0] c);
    @(posedge i_mclk);
    o_valid <= 1'h1;
    o_write <= w;
    o_cache <= c;
    @(posedge i_mclk);
    o_valid <= 1'h0;
    o_write <= ~w;
    o_cache <= ~c;
  endtask : send
endmodule : bao_txn_src

// ===== sim/tb_top.sv
// self-checking bench for the allocation hint override block
`timescale 1ns/10ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_total++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module tb_top;
  logic        mclk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, q, ctrl;
  logic        pready, pslverr, e, w, tv, tw, ov, ow;
  logic [3:0]  tc, oc, c;
  int          err_total = 0, checks = 0, nf = 0;
  // clock and partner
  always #2 mclk = ~mclk;
  bao_txn_src SRC (.i_mclk(mclk), .o_valid(tv), .o_write(tw), .o_cache(tc));
  bao_top DUT (.i_mclk(mclk), .i_arst_n(arst_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_txn_valid(tv), .i_txn_write(tw),
    .i_txn_cache(tc), .o_txn_valid(ov), .o_txn_write(ow), .o_txn_cache(oc));
  // expected attribute: only the own-direction hint, only with translation off
  function automatic logic [3:0] exp_c(logic [31:0] r, logic wr, logic [3:0] a);
    logic [1:0] f;
    f = wr ? r[27:26] : r[25:24];
    if (!r[0] && f[1]) a[wr ? 3 : 2] = ~f[0];
    return a;
  endfunction : exp_c
  // one apb transfer, waits for pready; only the watchdog ends a hang
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'h1);
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  // verdict and end of run
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : stop_test
  // watchdog, about ten times the expected run of some 500 cycles
  initial begin
    #20000;
    err_total++;
    stop_test();
  end
  // main sequence
  initial begin
    void'($urandom(94901));
    repeat (10) @(posedge mclk);
    arst_n <= 1'h1;
    apb(1'h0, 12'h000, 32'h0);
    `CHK(q, 32'h0)
    `CHK(e, 1'h0)
    apb(1'h1, 12'h000, 32'hFFFFFFFF);
    apb(1'h0, 12'h000, 32'h0);
    `CHK(q, 32'h0F000001)
    apb(1'h0, 12'h008, 32'h0);
    `CHK(e, 1'h1)
    $display("test registers done");
    // every field code, both translation states, corner and random attributes
    for (int i = 0; i < 32; i++) begin
      ctrl = $urandom;
      ctrl[27:24] = i[3:0];
      ctrl[0] = i[4];
      apb(1'h1, 12'h000, ctrl);
      for (int j = 0; j < 6; j++) begin
        w = (j < 4) ? j[0] : 1'($urandom);
        c = (j < 4) ? {4{j[1]}} : 4'($urandom);
        if (!ctrl[0] && (w ? ctrl[27] : ctrl[25])) nf++;
        SRC.send(w, c);
        #1;
        `CHK(ov, 1'h1)
        `CHK(ow, w)
        `CHK(oc, exp_c(ctrl, w, c))
      end
    end
    // status: forced count and translation mirror of the last setting
    apb(1'h0, 12'h004, 32'h0);
    `CHK(q, {15'h0000, ctrl[0], nf[15:0]})
    $display("test overrides done");
    stop_test();
  end
endmodule : tb_top
